//--- core/pcu_position_capture_unit.sv
// Purpose: Position capture for two capture inputs of a motion drive.
// Assumes: Inputs synchronous to clk in timing but asynchronous in origin; two-flop sync used.
// Notes: All results are read only; the write port is accepted and ignored.
//        Edge positions follow every edge, armed or not; input 2 edge counters are cleared by arming and miss an edge in the arming cycle.
`timescale 1ns/1ps
module pcu_position_capture_unit #(
   parameter int POS_W = 32,
   parameter int CNT_W = 16
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [1:0] capIn,
   input wire logic [1:0] capArm,
   input wire logic [1:0] capEdgeRising,
   input wire logic signed [POS_W-1:0] actPosition,
   input wire pcu_pkg::pcu_rebase_t rebase,
   input wire pcu_pkg::pcu_rd_req_t rdReq,
   input wire logic wrEn,
   input wire logic [15:0] wrAddr,
   input wire logic [31:0] wrData,
   output pcu_pkg::pcu_rd_rsp_t rdRsp,
   output logic [1:0] oneShotDone
);
   import pcu_pkg::*;

   // Positions take part in the reference shift, so only the full width is served.
   if (POS_W != PCU_POS_W) begin : g_chk_pos
      $error("position width must be 32");
   end

   // Counts are zero extended into a 32-bit read word.
   if (CNT_W < 1 || CNT_W > PCU_CNT_W) begin : g_chk_cnt
      $error("counter width must be 1 to 16");
   end

   logic [1:0] syncA_q;
   logic [1:0] syncB_q;
   logic [1:0] prev_q;
   pcu_edge_t edges [PCU_NUM_IN];

   pcu_shot_t shot_q [PCU_NUM_IN];
   logic [POS_W-1:0] oneShotPos_q [PCU_NUM_IN];
   logic [POS_W-1:0] contLive_q [PCU_NUM_IN];
   logic [POS_W-1:0] contVis_q [PCU_NUM_IN];
   logic [CNT_W-1:0] contCnt_q [PCU_NUM_IN];
   logic [POS_W-1:0] in1RisePos_q;
   logic [POS_W-1:0] in1FallPos_q;
   logic [CNT_W-1:0] in2RiseCnt_q;
   logic [CNT_W-1:0] in2FallCnt_q;
   logic [1:0] contCntRead;
   logic [1:0] shotTake;
   logic [31:0] rdData_d;
   logic unusedWr;

   // The shift is modular, matching the wrap of a 32-bit position.
   function automatic logic [POS_W-1:0] toFrame(input logic [POS_W-1:0] p,
                                              input logic [31:0] d);
      toFrame = p + d[POS_W-1:0];
   endfunction

   // Counters wrap silently; a reader tracking events must allow for the wrap.
   function automatic logic [CNT_W-1:0] bump(input logic [CNT_W-1:0] c);
      bump = c + CNT_W'(1);
   endfunction

   function automatic logic [31:0] widen(input logic [CNT_W-1:0] c);
      widen = {{(32-CNT_W){1'b0}}, c};
   endfunction

   // Count reads are decoded on the full address so no alias can freeze a position.
   function automatic logic cntReadHit(input pcu_rd_req_t r, input logic [15:0] a);
      cntReadHit = r.en && (r.addr == a);
   endfunction

   // The first stage feeds only the second; edges are judged on later stages.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         syncA_q <= 2'h0;
         syncB_q <= 2'h0;
      end else begin
         syncA_q <= capIn;
         syncB_q <= syncA_q;
      end
   end

   // Clearing the history to the idle level keeps reset from faking an edge.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         prev_q <= 2'h0;
      end else begin
         prev_q <= syncB_q;
      end
   end

   // A change of the chosen edge applies at once, also to an edge already in flight.
   always_comb begin
      for (int i = 0; i < PCU_NUM_IN; i++) begin
         edges[i].rise = syncB_q[i] & ~prev_q[i];
         edges[i].fall = ~syncB_q[i] & prev_q[i];
         edges[i].hit = capEdgeRising[i] ? edges[i].rise : edges[i].fall;
      end
   end

   assign contCntRead[0] = cntReadHit(rdReq, PCU_IN1_CONTINUOUS_COUNT);
   assign contCntRead[1] = cntReadHit(rdReq, PCU_IN2_CONTINUOUS_COUNT);

   // One-time capture: the first event after arming wins and later ones are ignored.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         for (int i = 0; i < PCU_NUM_IN; i++) begin
            shot_q[i] <= PCU_SHOT_IDLE;
         end
      end else begin
         for (int i = 0; i < PCU_NUM_IN; i++) begin
            unique case (shot_q[i])
               PCU_SHOT_IDLE: begin
                  if (capArm[i]) begin
                     shot_q[i] <= PCU_SHOT_ARMED;
                  end
               end
               PCU_SHOT_ARMED: begin
                  if (shotTake[i]) begin
                     shot_q[i] <= PCU_SHOT_DONE;
                  end
               end
               PCU_SHOT_DONE: begin
                  if (capArm[i]) begin
                     shot_q[i] <= PCU_SHOT_ARMED;
                  end
               end
               // A code outside the sequence falls back to idle rather than guessing a run.
               default: shot_q[i] <= PCU_SHOT_IDLE;
            endcase
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         for (int i = 0; i < PCU_NUM_IN; i++) begin
            oneShotPos_q[i] <= PCU_POS_RST;
         end
      end else begin
         for (int i = 0; i < PCU_NUM_IN; i++) begin
            if (shotTake[i]) begin
               oneShotPos_q[i] <= actPosition;
            end else if (rebase.stb) begin
               oneShotPos_q[i] <= toFrame(oneShotPos_q[i], rebase.delta);
            end
         end
      end
   end

   always_comb begin
      for (int i = 0; i < PCU_NUM_IN; i++) begin
         shotTake[i] = (shot_q[i] == PCU_SHOT_ARMED) && edges[i].hit && !capArm[i];
         oneShotDone[i] = (shot_q[i] == PCU_SHOT_DONE);
      end
   end

   // Continuous capture keeps a live latch that is never visible directly.
   // The visible copy takes the live value only on a counter read, which keeps count and
   // position a consistent pair however fast captures arrive.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         for (int i = 0; i < PCU_NUM_IN; i++) begin
            contLive_q[i] <= PCU_POS_RST;
         end
      end else begin
         for (int i = 0; i < PCU_NUM_IN; i++) begin
            if (edges[i].hit) begin
               contLive_q[i] <= actPosition;
            end else if (rebase.stb) begin
               contLive_q[i] <= toFrame(contLive_q[i], rebase.delta);
            end
         end
      end
   end

   // A read that meets a reference shift returns the shifted live value.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         for (int i = 0; i < PCU_NUM_IN; i++) begin
            contVis_q[i] <= PCU_POS_RST;
         end
      end else begin
         for (int i = 0; i < PCU_NUM_IN; i++) begin
            if (contCntRead[i]) begin
               contVis_q[i] <= rebase.stb ? toFrame(contLive_q[i], rebase.delta)
                                          : contLive_q[i];
            end else if (rebase.stb) begin
               contVis_q[i] <= toFrame(contVis_q[i], rebase.delta);
            end
         end
      end
   end

   // Arming clears counters; a capture in the arming cycle is not counted in either run.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         for (int i = 0; i < PCU_NUM_IN; i++) begin
            contCnt_q[i] <= PCU_CNT_RST[CNT_W-1:0];
         end
      end else begin
         for (int i = 0; i < PCU_NUM_IN; i++) begin
            if (capArm[i]) begin
               contCnt_q[i] <= PCU_CNT_RST[CNT_W-1:0];
            end else if (edges[i].hit) begin
               contCnt_q[i] <= bump(contCnt_q[i]);
            end
         end
      end
   end

   // Input 2 edge counters see both edges whatever edge is chosen for capture.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         in2RiseCnt_q <= PCU_CNT_RST[CNT_W-1:0];
      end else if (capArm[1]) begin
         in2RiseCnt_q <= PCU_CNT_RST[CNT_W-1:0];
      end else if (edges[1].rise) begin
         in2RiseCnt_q <= bump(in2RiseCnt_q);
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         in2FallCnt_q <= PCU_CNT_RST[CNT_W-1:0];
      end else if (capArm[1]) begin
         in2FallCnt_q <= PCU_CNT_RST[CNT_W-1:0];
      end else if (edges[1].fall) begin
         in2FallCnt_q <= bump(in2FallCnt_q);
      end
   end

   // Edge positions of input 1 follow every edge regardless of arming.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         in1RisePos_q <= PCU_POS_RST;
      end else if (edges[0].rise) begin
         in1RisePos_q <= actPosition;
      end else if (rebase.stb) begin
         in1RisePos_q <= toFrame(in1RisePos_q, rebase.delta);
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         in1FallPos_q <= PCU_POS_RST;
      end else if (edges[0].fall) begin
         in1FallPos_q <= actPosition;
      end else if (rebase.stb) begin
         in1FallPos_q <= toFrame(in1FallPos_q, rebase.delta);
      end
   end

   // Unmapped words read as zero so a master probing the range sees no stale data.
   always_comb begin
      rdData_d = PCU_RD_UNMAPPED;
      unique case (rdReq.addr)
         PCU_IN1_ONESHOT_POSITION: rdData_d = oneShotPos_q[0];
         PCU_IN2_ONESHOT_POSITION: rdData_d = oneShotPos_q[1];
         PCU_IN1_CONTINUOUS_COUNT: rdData_d = widen(contCnt_q[0]);
         PCU_IN1_CONTINUOUS_POSITION: rdData_d = contVis_q[0];
         PCU_IN2_CONTINUOUS_COUNT: rdData_d = widen(contCnt_q[1]);
         PCU_IN2_CONTINUOUS_POSITION: rdData_d = contVis_q[1];
         PCU_IN1_RISING_POSITION: rdData_d = in1RisePos_q;
         PCU_IN1_FALLING_POSITION: rdData_d = in1FallPos_q;
         PCU_IN2_RISING_COUNT: rdData_d = widen(in2RiseCnt_q);
         PCU_IN2_FALLING_COUNT: rdData_d = widen(in2FallCnt_q);
         default: rdData_d = PCU_RD_UNMAPPED;
      endcase
   end

   // Data is zero outside a read so a late sampler cannot pick up a stale word.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         rdRsp <= '0;
      end else begin
         rdRsp.valid <= rdReq.en;
         rdRsp.data <= rdReq.en ? rdData_d : PCU_RD_UNMAPPED;
      end
   end

   // Nothing in this block is writable; the write port exists only so the
   // parameter channel can be wired uniformly and is deliberately dropped.
   assign unusedWr = wrEn & (|wrAddr) & (|wrData);
endmodule

//--- core/pcu_pkg.sv
// Purpose: Shared constants and types for the position capture unit.
// Assumes: Register offsets are parameter addresses on the drive's parameter read port.
// Notes: Offsets are word addresses as seen by the fieldbus side, not byte addresses.
package pcu_pkg;
   localparam int PCU_POS_W = 32;
   localparam int PCU_CNT_W = 16;
   localparam int PCU_ADDR_W = 16;
   localparam int PCU_NUM_IN = 2;

   // Parameter addresses of the capture results.
   localparam logic [15:0] PCU_IN1_ONESHOT_POSITION = 16'h0a0c;
   localparam logic [15:0] PCU_IN2_ONESHOT_POSITION = 16'h0a0e;
   localparam logic [15:0] PCU_IN1_CONTINUOUS_COUNT = 16'h0a2e;
   localparam logic [15:0] PCU_IN1_CONTINUOUS_POSITION = 16'h0a30;
   localparam logic [15:0] PCU_IN2_CONTINUOUS_COUNT = 16'h0a32;
   localparam logic [15:0] PCU_IN2_CONTINUOUS_POSITION = 16'h0a34;
   localparam logic [15:0] PCU_IN1_RISING_POSITION = 16'h0a4a;
   localparam logic [15:0] PCU_IN1_FALLING_POSITION = 16'h0a4c;
   localparam logic [15:0] PCU_IN2_RISING_COUNT = 16'h0a5a;
   localparam logic [15:0] PCU_IN2_FALLING_COUNT = 16'h0a5c;

   // Reset values and the read value of unmapped words.
   localparam logic [31:0] PCU_POS_RST = 32'h0000_0000;
   localparam logic [15:0] PCU_CNT_RST = 16'h0000;
   localparam logic [31:0] PCU_RD_UNMAPPED = 32'h0000_0000;

   // One-time capture sequence, Gray coded along idle, armed, done.
   typedef enum logic [1:0] {
      PCU_SHOT_IDLE = 2'b00,
      PCU_SHOT_ARMED = 2'b01,
      PCU_SHOT_DONE = 2'b11
   } pcu_shot_t;

   // Edge events of one synchronised capture input.
   typedef struct packed {
      logic rise;
      logic fall;
      logic hit;
   } pcu_edge_t;

   // Parameter read request and answer.
   typedef struct packed {
      logic en;
      logic [15:0] addr;
   } pcu_rd_req_t;

   typedef struct packed {
      logic valid;
      logic [31:0] data;
   } pcu_rd_rsp_t;

   // Position reference redefinition (position setting or homing).
   typedef struct packed {
      logic stb;
      logic [31:0] delta;
   } pcu_rebase_t;
endpackage

//--- testbench/pcu_capture_asserts.sv
// Purpose: Port-level assertions for the position capture unit.
// Assumes: Reads answer one cycle after the request; capture needs three edges.
// Notes: Bound from the bench top file.
`timescale 1ns/1ps
module pcu_capture_asserts (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [1:0] capIn,
   input wire logic [1:0] capArm,
   input wire pcu_pkg::pcu_rebase_t rebase,
   input wire pcu_pkg::pcu_rd_req_t rdReq,
   input wire pcu_pkg::pcu_rd_rsp_t rdRsp,
   input wire logic [1:0] oneShotDone
);
   import pcu_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   wire shotRd = rdReq.en && rdReq.addr == PCU_IN1_ONESHOT_POSITION && !capArm[0] && !rebase.stb;
   wire riseRd = rdReq.en && rdReq.addr == PCU_IN2_RISING_COUNT;
   sequence s_shot_twice;
      (shotRd && oneShotDone[0]) ##1 (!capArm[0] && !rebase.stb) ##1 shotRd;
   endsequence
   // The input must be quiet long enough that no edge is still in the synchroniser.
   sequence s_arm_read;
      $stable(capIn)[*4] ##0 capArm[1] ##1 $stable(capIn) ##1 ($stable(capIn) && riseRd);
   endsequence
   a_rsp_next: assert property (rdReq.en |=> rdRsp.valid)
      else $error("read not answered next cycle");
   a_rsp_lone: assert property (!rdReq.en |=> !rdRsp.valid)
      else $error("answer without a read");
   a_idle_zero: assert property (!rdRsp.valid |-> rdRsp.data == '0)
      else $error("data not zero while idle");
   a_odd_unmapped: assert property (rdReq.en && rdReq.addr[0] |=> rdRsp.data == '0)
      else $error("unmapped read not zero");
   a_cnt_zext: assert property (riseRd |=> rdRsp.data[31:16] == 16'h0000)
      else $error("count not zero extended");
   a_arm_done: assert property (capArm[0] |=> !oneShotDone[0])
      else $error("arm did not restart one-time capture");
   a_done_holds: assert property (oneShotDone[0] && !capArm[0] |=> oneShotDone[0])
      else $error("one-time done dropped without arm");
   a_shot_kept: assert property (s_shot_twice |=> rdRsp.data == $past(rdRsp.data, 2))
      else $error("one-time position changed after capture");
   a_arm_zero: assert property (s_arm_read |=> rdRsp.data == '0)
      else $error("counter not cleared by arm");
endmodule

//--- testbench/pcu_bus_master.sv
// Purpose: Fieldbus master model issuing parameter reads.
// Assumes: One read in flight at a time.
// Notes: An idle cycle separates reads, so the request never changes twice in one step.
`timescale 1ns/1ps
module pcu_bus_master (
   input wire logic clk,
   output pcu_pkg::pcu_rd_req_t rdReq
);
   import pcu_pkg::*;
   initial rdReq = '0;
   task automatic read(input logic [15:0] a);
      @(posedge clk);
      rdReq <= '{1'b1, a};
      @(posedge clk);
      rdReq <= '0;
   endtask
endmodule

//--- testbench/pcu_position_capture_unit_bench.sv
// Purpose: Self-checking bench for the position capture unit.
// Assumes: A capture input change is taken three edges later.
// Notes: Counter wrap is not run; it would need 65536 events.
`timescale 1ns/1ps
module pcu_position_capture_unit_bench;
   import pcu_pkg::*;
   logic clk = 1'h0;
   logic rst_b = 1'h0;
   logic [1:0] capIn = 2'h0;
   logic [1:0] capArm = 2'h0;
   logic [1:0] capEdgeRising = 2'h1;
   logic [1:0] oneShotDone;
   logic signed [31:0] actPosition = 32'h0;
   pcu_rebase_t rebase = '0;
   pcu_rd_req_t rdReq;
   pcu_rd_rsp_t rdRsp;
   logic wrEn = 1'h0;
   logic [15:0] wrAddr = 16'h0;
   logic [31:0] wrData = 32'h0;
   logic [31:0] seed = 32'h2b76;
   logic [31:0] d;
   logic [31:0] p[8];
   logic [31:0] expQ[$];
   logic [15:0] regs[7] = '{PCU_IN1_ONESHOT_POSITION, PCU_IN1_CONTINUOUS_COUNT,
      PCU_IN1_CONTINUOUS_POSITION, PCU_IN1_RISING_POSITION, PCU_IN1_FALLING_POSITION,
      PCU_IN2_RISING_COUNT, PCU_IN2_FALLING_COUNT};
   int err_total = 0;
   int num_checks = 0;
   always #5 clk = ~clk;
   pcu_position_capture_unit i_dut(.clk(clk), .rst_b(rst_b), .capIn(capIn), .capArm(capArm),
      .capEdgeRising(capEdgeRising), .actPosition(actPosition), .rebase(rebase),
      .rdReq(rdReq), .wrEn(wrEn), .wrAddr(wrAddr), .wrData(wrData), .rdRsp(rdRsp),
      .oneShotDone(oneShotDone));
   pcu_bus_master i_master(.clk(clk), .rdReq(rdReq));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic rd(input logic [15:0] a, input logic [31:0] e);
      expQ.push_back(e);
      i_master.read(a);
   endtask
   // Position is held until the capture edge has passed the synchroniser.
   task automatic cap(input int i, input logic v, input logic [31:0] pos);
      @(posedge clk);
      capIn[i] <= v;
      actPosition <= pos;
      repeat (4) @(posedge clk);
   endtask
   task automatic arm(input logic [1:0] m);
      @(posedge clk);
      capArm <= m;
      @(posedge clk);
      capArm <= 2'h0;
   endtask
   always @(posedge clk) begin
      if (rdRsp.valid === 1'b1) begin
         if (expQ.size() == 0) check(rdRsp.data, ~rdRsp.data);
         else check(rdRsp.data, expQ.pop_front());
      end
   end
   initial begin
      repeat (5000) @(posedge clk);
      err_total++;
      give_verdict();
   end
   initial begin
      for (int k = 0; k < 8; k++) p[k] = rnd();
      d = rnd();
      repeat (20) @(posedge clk);
      rst_b <= 1'h1;
      check({30'h0, oneShotDone}, 32'h0);
      foreach (regs[k]) rd(regs[k], 32'h0);
      rd(16'h0a01, 32'h0);
      arm(2'h3);
      cap(0, 1'b1, p[0]);
      cap(0, 1'b0, p[1]);
      cap(0, 1'b1, p[2]);
      check({30'h0, oneShotDone}, 32'h1);
      rd(PCU_IN1_CONTINUOUS_COUNT, 32'h2);
      cap(0, 1'b0, p[3]);
      cap(0, 1'b1, p[4]);
      rd(PCU_IN1_CONTINUOUS_POSITION, p[2]);
      rd(PCU_IN1_ONESHOT_POSITION, p[0]);
      rd(PCU_IN1_ONESHOT_POSITION, p[0]);
      rd(PCU_IN1_RISING_POSITION, p[4]);
      rd(PCU_IN1_FALLING_POSITION, p[3]);
      rd(PCU_IN1_CONTINUOUS_COUNT, 32'h3);
      rd(PCU_IN1_CONTINUOUS_POSITION, p[4]);
      cap(1, 1'b1, p[5]);
      cap(1, 1'b0, p[6]);
      cap(1, 1'b1, p[7]);
      rd(PCU_IN2_RISING_COUNT, 32'h2);
      rd(PCU_IN2_FALLING_COUNT, 32'h1);
      rd(PCU_IN2_CONTINUOUS_COUNT, 32'h1);
      rd(PCU_IN2_CONTINUOUS_POSITION, p[6]);
      rd(PCU_IN2_ONESHOT_POSITION, p[6]);
      @(posedge clk);
      rebase <= '{1'b1, d};
      @(posedge clk);
      rebase <= '0;
      rd(PCU_IN1_ONESHOT_POSITION, p[0] + d);
      rd(PCU_IN1_CONTINUOUS_POSITION, p[4] + d);
      rd(PCU_IN1_FALLING_POSITION, p[3] + d);
      @(posedge clk);
      wrEn <= 1'h1;
      wrAddr <= PCU_IN1_CONTINUOUS_COUNT;
      wrData <= rnd();
      @(posedge clk);
      wrEn <= 1'h0;
      rd(PCU_IN1_CONTINUOUS_COUNT, 32'h3);
      arm(2'h2);
      rd(PCU_IN2_RISING_COUNT, 32'h0);
      arm(2'h1);
      rd(PCU_IN1_CONTINUOUS_COUNT, 32'h0);
      check({30'h0, oneShotDone}, 32'h0);
      // Swap the chosen edges: input 1 now captures on falling, input 2 on rising.
      @(posedge clk);
      capEdgeRising <= 2'h2;
      cap(0, 1'b0, p[5]);
      rd(PCU_IN1_ONESHOT_POSITION, p[5]);
      rd(PCU_IN1_CONTINUOUS_COUNT, 32'h1);
      rd(PCU_IN1_FALLING_POSITION, p[5]);
      cap(1, 1'b0, p[2]);
      cap(1, 1'b1, p[3]);
      rd(PCU_IN2_CONTINUOUS_COUNT, 32'h1);
      cap(1, 1'b0, p[6]);
      cap(1, 1'b1, p[4]);
      rd(PCU_IN2_CONTINUOUS_POSITION, p[3]);
      rd(PCU_IN2_ONESHOT_POSITION, p[3]);
      rd(PCU_IN2_FALLING_COUNT, 32'h2);
      rd(PCU_IN2_RISING_COUNT, 32'h2);
      rd(PCU_IN2_CONTINUOUS_COUNT, 32'h2);
      rd(PCU_IN2_CONTINUOUS_POSITION, p[4]);
      for (int k = 0; k < 10 && expQ.size() > 0; k++) @(posedge clk);
      if (expQ.size() > 0) err_total++;
      give_verdict();
   end
endmodule
bind pcu_position_capture_unit pcu_capture_asserts i_chk(.clk(clk), .rst_b(rst_b),
   .capIn(capIn), .capArm(capArm), .rebase(rebase), .rdReq(rdReq), .rdRsp(rdRsp),
   .oneShotDone(oneShotDone));
